//--- cmp_regs_pkg.sv
package cmp_regs_pkg;

   // ---------------------------------------------------------------
   // register map (byte addresses)
   // ---------------------------------------------------------------
   localparam logic [31:0] OFF_CTRL1  = 32'h0000_0000;
   localparam logic [31:0] OFF_CTRL2  = 32'h0000_0004;
   localparam logic [31:0] OFF_AUX    = 32'h0000_0008;
   localparam logic [31:0] OFF_STATUS = 32'h0000_000C;
   localparam logic [31:0] OFF_MASK   = 32'h0000_0010;

   // ---------------------------------------------------------------
   // primary control field positions
   // ---------------------------------------------------------------
   localparam int POS_ENABLE   = 7;
   localparam int POS_RESULT   = 6;
   localparam int POS_DRIVE    = 5;
   localparam int POS_INVERT   = 4;
   localparam int POS_REF      = 2;
   localparam int POS_CH_HI    = 1;
   localparam int POS_CH_LO    = 0;
   localparam logic [7:0] CTRL_WRITE_MASK = 8'hB7;

   // ---------------------------------------------------------------
   // auxiliary control field positions
   // ---------------------------------------------------------------
   localparam int POS_MIRROR1  = 7;
   localparam int POS_MIRROR2  = 6;
   localparam int POS_GATE_SRC = 1;
   localparam int POS_SYNC_SEL = 0;

   // ---------------------------------------------------------------
   // reset values
   // ---------------------------------------------------------------
   localparam logic [7:0] CTRL_RESET     = 8'h00;
   localparam logic       GATE_SRC_RESET = 1'h1;
   localparam logic       SYNC_SEL_RESET = 1'h0;
   localparam logic [1:0] STATUS_RESET   = 2'h0;
   localparam logic [1:0] MASK_RESET     = 2'h0;

   // ---------------------------------------------------------------
   // bus answers
   // ---------------------------------------------------------------
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum {
      SEL_CTRL1,
      SEL_CTRL2,
      SEL_AUX,
      SEL_STATUS,
      SEL_MASK,
      SEL_NONE
   } reg_sel_type;

   function automatic reg_sel_type decode_addr(input logic [31:0] addr);
      reg_sel_type sel;
      case (addr)
         OFF_CTRL1:  sel = SEL_CTRL1;
         OFF_CTRL2:  sel = SEL_CTRL2;
         OFF_AUX:    sel = SEL_AUX;
         OFF_STATUS: sel = SEL_STATUS;
         OFF_MASK:   sel = SEL_MASK;
         default:    sel = SEL_NONE;
      endcase
      return sel;
   endfunction : decode_addr

endpackage : cmp_regs_pkg

//--- reg_access_if.sv
`timescale 1ns/1ps
`default_nettype none

interface reg_access_if;
   logic        wr_en;
   logic [31:0] wr_addr;
   logic [31:0] wr_data;
   logic [3:0]  wr_strb;
   logic        wr_err;
   logic        rd_en;
   logic [31:0] rd_addr;
   logic [31:0] rd_data;
   logic        rd_err;

   modport bus
   (
      output wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr,
      input  wr_err, rd_data, rd_err
   );

   modport regs
   (
      input  wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr,
      output wr_err, rd_data, rd_err
   );
endinterface : reg_access_if

`default_nettype wire

//--- axi_lite_slave.sv
`timescale 1ns/1ps
`default_nettype none

module axi_lite_slave
(
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rstn,
   // write channels
   input  wire logic [31:0] awaddr,
   input  wire logic        awvalid,
   output logic             awready,
   input  wire logic [31:0] wdata,
   input  wire logic [3:0]  wstrb,
   input  wire logic        wvalid,
   output logic             wready,
   output logic [1:0]       bresp,
   output logic             bvalid,
   input  wire logic        bready,
   // read channels
   input  wire logic [31:0] araddr,
   input  wire logic        arvalid,
   output logic             arready,
   output logic [31:0]      rdata,
   output logic [1:0]       rresp,
   output logic             rvalid,
   input  wire logic        rready,
   // register side
   reg_access_if.bus        acc
);

   typedef struct packed {
      logic        aw_held;
      logic        w_held;
      logic [31:0] awaddr;
      logic [31:0] wdata;
      logic [3:0]  wstrb;
      logic        awready;
      logic        wready;
      logic        arready;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
   } axi_state_type;

   axi_state_type s;
   axi_state_type next_s;
   logic          do_write;
   logic          do_read;

   // ---------------------------------------------------------------
   // channel handling
   // ---------------------------------------------------------------
   // address and data may arrive in either order; the write is
   // carried out in the first cycle that both are held
   always_comb
   begin
      next_s   = s;
      do_write = s.aw_held && s.w_held;
      do_read  = arvalid && s.arready;
      if (awvalid && s.awready)
      begin
         next_s.aw_held = 1'b1;
         next_s.awaddr  = awaddr;
      end
      if (wvalid && s.wready)
      begin
         next_s.w_held = 1'b1;
         next_s.wdata  = wdata;
         next_s.wstrb  = wstrb;
      end
      if (s.bvalid && bready)
         next_s.bvalid = 1'b0;
      if (do_write)
      begin
         next_s.aw_held = 1'b0;
         next_s.w_held  = 1'b0;
         next_s.bvalid  = 1'b1;
         next_s.bresp   = acc.wr_err ? cmp_regs_pkg::RESP_SLVERR
                                     : cmp_regs_pkg::RESP_OKAY;
      end
      if (s.rvalid && rready)
         next_s.rvalid = 1'b0;
      if (do_read)
      begin
         next_s.rvalid = 1'b1;
         next_s.rdata  = acc.rd_data;
         next_s.rresp  = acc.rd_err ? cmp_regs_pkg::RESP_SLVERR
                                    : cmp_regs_pkg::RESP_OKAY;
      end
      next_s.awready = !next_s.aw_held && !next_s.bvalid;
      next_s.wready  = !next_s.w_held && !next_s.bvalid;
      next_s.arready = !next_s.rvalid;
   end

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         s         <= '0;
         s.awready <= 1'b1;
         s.wready  <= 1'b1;
         s.arready <= 1'b1;
      end
      else
         s <= next_s;
   end

   assign acc.wr_en   = do_write;
   assign acc.wr_addr = s.awaddr;
   assign acc.wr_data = s.wdata;
   assign acc.wr_strb = s.wstrb;
   assign acc.rd_en   = do_read;
   assign acc.rd_addr = araddr;

   assign awready = s.awready;
   assign wready  = s.wready;
   assign bvalid  = s.bvalid;
   assign bresp   = s.bresp;
   assign arready = s.arready;
   assign rvalid  = s.rvalid;
   assign rdata   = s.rdata;
   assign rresp   = s.rresp;

endmodule : axi_lite_slave

`default_nettype wire

//--- cmp_channel.sv
`timescale 1ns/1ps
`default_nettype none

module cmp_channel
(
   // clock and reset
   input  wire logic clk,
   input  wire logic rstn,
   // analog core and control
   input  wire logic raw,
   input  wire logic enable,
   input  wire logic invert,
   input  wire logic capture,
   // results
   output logic      result,
   output logic      change_event
);

   typedef struct packed {
      logic [2:0] sync;
      logic       level;
      logic       ref_latch;
      logic       mismatch;
   } chan_state_type;

   chan_state_type s;
   chan_state_type next_s;
   logic           mis;

   // ---------------------------------------------------------------
   // input filter, polarity and mismatch detection
   // ---------------------------------------------------------------
   // the raw output is asynchronous; a change only counts once the
   // second and third stages agree, which also masks short glitches
   always_comb
   begin
      next_s      = s;
      next_s.sync = {s.sync[1:0], raw};
      if (s.sync[1] == s.sync[2])
         next_s.level = s.sync[2];
      // a disabled comparator reads low
      result = enable && (s.level ^ invert);
      mis    = result != s.ref_latch;
      // edge, not level: one event per new mismatch
      change_event = mis && !s.mismatch;
      next_s.mismatch = mis && !capture;
      if (capture)
         next_s.ref_latch = result;
   end

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         s <= '0;
      else
         s <= next_s;
   end

endmodule : cmp_channel

`default_nettype wire

//--- dual_comparator_control_regs.sv
// Chosen here: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none

module dual_comparator_control_regs
(
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rstn,
   // axi4-lite write channels
   input  wire logic [31:0] awaddr,
   input  wire logic        awvalid,
   output logic             awready,
   input  wire logic [31:0] wdata,
   input  wire logic [3:0]  wstrb,
   input  wire logic        wvalid,
   output logic             wready,
   output logic [1:0]       bresp,
   output logic             bvalid,
   input  wire logic        bready,
   // axi4-lite read channels
   input  wire logic [31:0] araddr,
   input  wire logic        arvalid,
   output logic             arready,
   output logic [31:0]      rdata,
   output logic [1:0]       rresp,
   output logic             rvalid,
   input  wire logic        rready,
   // analog comparator core
   input  wire logic        cmp_raw,
   input  wire logic        cmp2_raw,
   output logic             cmp_enable,
   output logic             cmp2_enable,
   output logic             cmp_ref_select,
   output logic             cmp2_ref_select,
   output logic [1:0]       cmp_channel_select,
   output logic [1:0]       cmp2_channel_select,
   output logic             vref_enable,
   // port pins
   input  wire logic [1:0]  pin_direction,
   output logic             cmp_pin_out,
   output logic             cmp_pin_oe,
   output logic             cmp2_pin_out,
   output logic             cmp2_pin_oe,
   // interrupt
   output logic             irq
);

   typedef struct packed {
      logic [1:0][7:0] ctrl;
      logic            gate_src;
      logic            sync_sel;
      logic [1:0]      status;
      logic [1:0]      mask;
      logic            irq;
      logic [1:0]      pin_out;
      logic [1:0]      pin_oe;
      logic            vref_on;
   } top_state_type;

   top_state_type            s;
   top_state_type            next_s;
   reg_access_if             acc ();
   cmp_regs_pkg::reg_sel_type wr_sel;
   cmp_regs_pkg::reg_sel_type rd_sel;
   logic [1:0]               raw;
   logic [1:0]               result;
   logic [1:0]               change_event;
   logic [1:0]               capture;
   logic [7:0]               rd_byte;

   assign raw = {cmp2_raw, cmp_raw};

   // ---------------------------------------------------------------
   // bus slave
   // ---------------------------------------------------------------
   axi_lite_slave u_bus
   (
      .clk     (clk),
      .rstn    (rstn),
      .awaddr  (awaddr),
      .awvalid (awvalid),
      .awready (awready),
      .wdata   (wdata),
      .wstrb   (wstrb),
      .wvalid  (wvalid),
      .wready  (wready),
      .bresp   (bresp),
      .bvalid  (bvalid),
      .bready  (bready),
      .araddr  (araddr),
      .arvalid (arvalid),
      .arready (arready),
      .rdata   (rdata),
      .rresp   (rresp),
      .rvalid  (rvalid),
      .rready  (rready),
      .acc     (acc.bus)
   );

   assign wr_sel = cmp_regs_pkg::decode_addr(acc.wr_addr);
   assign rd_sel = cmp_regs_pkg::decode_addr(acc.rd_addr);

   // a write counts as an access too, so it re-arms the mismatch
   // reference just like a read
   assign capture[0] = (acc.rd_en && rd_sel == cmp_regs_pkg::SEL_CTRL1)
                    || (acc.wr_en && wr_sel == cmp_regs_pkg::SEL_CTRL1);
   assign capture[1] = (acc.rd_en && rd_sel == cmp_regs_pkg::SEL_CTRL2)
                    || (acc.wr_en && wr_sel == cmp_regs_pkg::SEL_CTRL2);

   // ---------------------------------------------------------------
   // comparator channels
   // ---------------------------------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++)
      begin : g_chan
         cmp_channel u_chan
         (
            .clk          (clk),
            .rstn         (rstn),
            .raw          (raw[gi]),
            .enable       (s.ctrl[gi][cmp_regs_pkg::POS_ENABLE]),
            .invert       (s.ctrl[gi][cmp_regs_pkg::POS_INVERT]),
            .capture      (capture[gi]),
            .result       (result[gi]),
            .change_event (change_event[gi])
         );
      end
   endgenerate

   // ---------------------------------------------------------------
   // read path
   // ---------------------------------------------------------------
   always_comb
   begin
      rd_byte    = 8'h00;
      acc.rd_err = 1'b0;
      case (rd_sel)
         cmp_regs_pkg::SEL_CTRL1:
         begin
            rd_byte = s.ctrl[0];
            rd_byte[cmp_regs_pkg::POS_RESULT] = result[0];
         end
         cmp_regs_pkg::SEL_CTRL2:
         begin
            rd_byte = s.ctrl[1];
            rd_byte[cmp_regs_pkg::POS_RESULT] = result[1];
         end
         cmp_regs_pkg::SEL_AUX:
         begin
            // mirror bits do not touch the mismatch reference
            rd_byte[cmp_regs_pkg::POS_MIRROR1]  = result[0];
            rd_byte[cmp_regs_pkg::POS_MIRROR2]  = result[1];
            rd_byte[cmp_regs_pkg::POS_GATE_SRC] = s.gate_src;
            rd_byte[cmp_regs_pkg::POS_SYNC_SEL] = s.sync_sel;
         end
         cmp_regs_pkg::SEL_STATUS:
            rd_byte[1:0] = s.status;
         cmp_regs_pkg::SEL_MASK:
            rd_byte[1:0] = s.mask;
         default:
            acc.rd_err = 1'b1;
      endcase
      acc.rd_data = {24'h00_0000, rd_byte};
   end

   assign acc.wr_err = (wr_sel == cmp_regs_pkg::SEL_NONE);

   // ---------------------------------------------------------------
   // register update
   // ---------------------------------------------------------------
   always_comb
   begin
      next_s = s;
      // only byte lane 0 carries register bits
      if (acc.wr_en && acc.wr_strb[0])
      begin
         case (wr_sel)
            cmp_regs_pkg::SEL_CTRL1:
               next_s.ctrl[0] = acc.wr_data[7:0]
                              & cmp_regs_pkg::CTRL_WRITE_MASK;
            cmp_regs_pkg::SEL_CTRL2:
               next_s.ctrl[1] = acc.wr_data[7:0]
                              & cmp_regs_pkg::CTRL_WRITE_MASK;
            cmp_regs_pkg::SEL_AUX:
            begin
               next_s.gate_src =
                  acc.wr_data[cmp_regs_pkg::POS_GATE_SRC];
               next_s.sync_sel =
                  acc.wr_data[cmp_regs_pkg::POS_SYNC_SEL];
            end
            cmp_regs_pkg::SEL_STATUS:
               next_s.status = s.status & ~acc.wr_data[1:0];
            cmp_regs_pkg::SEL_MASK:
               next_s.mask = acc.wr_data[1:0];
            default:
               next_s.mask = s.mask;
         endcase
      end
      // an event in the clearing cycle still lands
      next_s.status = next_s.status | change_event;
      next_s.irq    = |(next_s.status & next_s.mask);
      for (int i = 0; i < 2; i++)
      begin
         // pin override needs all three conditions at once
         next_s.pin_oe[i] = next_s.ctrl[i][cmp_regs_pkg::POS_DRIVE]
                         && next_s.ctrl[i][cmp_regs_pkg::POS_ENABLE]
                         && !pin_direction[i];
         next_s.pin_out[i] = result[i];
      end
      // reference runs only while an enabled channel selects it
      next_s.vref_on =
         (next_s.ctrl[0][cmp_regs_pkg::POS_ENABLE]
          && next_s.ctrl[0][cmp_regs_pkg::POS_REF])
         || (next_s.ctrl[1][cmp_regs_pkg::POS_ENABLE]
          && next_s.ctrl[1][cmp_regs_pkg::POS_REF]);
   end

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         s          <= '0;
         s.ctrl[0]  <= cmp_regs_pkg::CTRL_RESET;
         s.ctrl[1]  <= cmp_regs_pkg::CTRL_RESET;
         s.gate_src <= cmp_regs_pkg::GATE_SRC_RESET;
         s.sync_sel <= cmp_regs_pkg::SYNC_SEL_RESET;
         s.status   <= cmp_regs_pkg::STATUS_RESET;
         s.mask     <= cmp_regs_pkg::MASK_RESET;
      end
      else
         s <= next_s;
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   assign cmp_enable  = s.ctrl[0][cmp_regs_pkg::POS_ENABLE];
   assign cmp2_enable = s.ctrl[1][cmp_regs_pkg::POS_ENABLE];
   assign cmp_ref_select  = s.ctrl[0][cmp_regs_pkg::POS_REF];
   assign cmp2_ref_select = s.ctrl[1][cmp_regs_pkg::POS_REF];
   assign cmp_channel_select  = s.ctrl[0][1:0];
   assign cmp2_channel_select = s.ctrl[1][1:0];
   assign vref_enable  = s.vref_on;
   assign cmp_pin_out  = s.pin_out[0];
   assign cmp_pin_oe   = s.pin_oe[0];
   assign cmp2_pin_out = s.pin_out[1];
   assign cmp2_pin_oe  = s.pin_oe[1];
   assign irq          = s.irq;

endmodule : dual_comparator_control_regs

`default_nettype wire

//--- dual_comparator_control_regs_props.sv
`timescale 1ns/1ps
`default_nettype none

module dual_comparator_control_regs_props
(
   // clock and reset
   input wire logic       clk,
   input wire logic       rstn,
   // bus handshakes
   input wire logic       awvalid,
   input wire logic       awready,
   input wire logic       wvalid,
   input wire logic       wready,
   input wire logic [1:0] bresp,
   input wire logic       bvalid,
   input wire logic       bready,
   input wire logic       arvalid,
   input wire logic       arready,
   input wire logic       rvalid,
   // comparator core and pins
   input wire logic       cmp_enable,
   input wire logic       cmp2_enable,
   input wire logic       cmp_ref_select,
   input wire logic       cmp2_ref_select,
   input wire logic [1:0] cmp_channel_select,
   input wire logic [1:0] cmp2_channel_select,
   input wire logic       vref_enable,
   input wire logic [1:0] pin_direction,
   input wire logic       cmp_pin_out,
   input wire logic       cmp_pin_oe,
   input wire logic       irq
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rstn);

   logic [7:0] ctl_out;
   logic       vref_cause;
   assign ctl_out = {cmp_enable, cmp2_enable, cmp_ref_select,
                     cmp2_ref_select, cmp_channel_select,
                     cmp2_channel_select};
   assign vref_cause = (cmp_enable & cmp_ref_select)
                     | (cmp2_enable & cmp2_ref_select);

   // ---------------------------------------------------------------
   // sequences
   // ---------------------------------------------------------------
   sequence s_wr_taken;
      awvalid && awready && wvalid && wready;
   endsequence
   sequence s_wr_answer;
      ##[1:2] bvalid;
   endsequence
   sequence s_rd_taken;
      arvalid && arready;
   endsequence

   // ---------------------------------------------------------------
   // properties
   // ---------------------------------------------------------------
   property p_reset_off;
      $rose(rstn) |-> !cmp_enable && !cmp2_enable && !vref_enable
                      && !cmp_pin_oe && !irq;
   endproperty
   a_reset_off: assert property (p_reset_off)
      else $error("outputs not off after reset");
   property p_ctl_write;
      $changed(ctl_out) |-> $rose(bvalid);
   endproperty
   a_ctl_write: assert property (p_ctl_write)
      else $error("control output moved without a write");
   property p_oe_enable;
      cmp_pin_oe |-> cmp_enable || $past(cmp_enable);
   endproperty
   a_oe_enable: assert property (p_oe_enable)
      else $error("pin driven while comparator off");
   property p_oe_dir;
      pin_direction[0] [*3] |-> !cmp_pin_oe;
   endproperty
   a_oe_dir: assert property (p_oe_dir)
      else $error("pin driven while direction is input");
   property p_pin_off;
      !cmp_enable [*4] |-> !cmp_pin_out;
   endproperty
   a_pin_off: assert property (p_pin_off)
      else $error("result high while comparator off");
   property p_vref;
      vref_enable |-> vref_cause || $past(vref_cause);
   endproperty
   a_vref: assert property (p_vref)
      else $error("reference on with no user");
   property p_w_lat;
      s_wr_taken |-> s_wr_answer;
   endproperty
   a_w_lat: assert property (p_w_lat)
      else $error("write answer late");
   property p_b_hold;
      bvalid && !bready |=> bvalid && $stable(bresp);
   endproperty
   a_b_hold: assert property (p_b_hold)
      else $error("write answer dropped");
   property p_r_lat;
      s_rd_taken |=> rvalid && !arready;
   endproperty
   a_r_lat: assert property (p_r_lat)
      else $error("read answer late");
endmodule : dual_comparator_control_regs_props

bind dual_comparator_control_regs dual_comparator_control_regs_props u_props
(
   .clk, .rstn, .awvalid, .awready, .wvalid, .wready, .bresp, .bvalid,
   .bready, .arvalid, .arready, .rvalid, .cmp_enable, .cmp2_enable,
   .cmp_ref_select, .cmp2_ref_select, .cmp_channel_select,
   .cmp2_channel_select, .vref_enable, .pin_direction, .cmp_pin_out,
   .cmp_pin_oe, .irq
);

`default_nettype wire

//--- cmp_analog_model.sv
`timescale 1ns/1ps
`default_nettype none

module cmp_analog_model
(
   // clock
   input  wire logic       clk,
   // comparison wanted by the bench, bit set = plus input above
   input  wire logic [1:0] above,
   // design side
   input  wire logic [1:0] enable,
   input  wire logic [1:0] pin_out,
   input  wire logic [1:0] pin_oe,
   output logic            cmp_raw,
   output logic            cmp2_raw,
   output logic [1:0]      pad
);
   logic [1:0] raw  = 2'h0;
   logic [1:0] last = 2'h0;

   always_ff @(posedge clk)
   begin
      // a powered-down core gives no valid answer, so it toggles
      raw  <= (enable & above) | (~enable & ~raw);
      last <= pad;
   end
   assign cmp_raw  = raw[0];
   assign cmp2_raw = raw[1];
   // an undriven pin with no pull shows the inverse of its last level
   assign pad = (pin_oe & pin_out) | (~pin_oe & ~last);
endmodule : cmp_analog_model

`default_nettype wire

//--- dual_comparator_control_regs_bench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin \
   miscompares++; \
   $display("[FAIL] %s expected %h seen %h", nm, ex, got); end end

module dual_comparator_control_regs_bench;
   logic        clk, rstn, awvalid, awready, wvalid, wready, bvalid;
   logic        bready, arvalid, arready, rvalid, rready, irq;
   logic [31:0] awaddr, wdata, araddr, rdata, d;
   logic [3:0]  wstrb;
   logic [1:0]  bresp, rresp, pin_direction, above, pad;
   logic        cmp_raw, cmp2_raw, cmp_enable, cmp2_enable, vref_enable;
   logic        cmp_ref_select, cmp2_ref_select, cmp_pin_out, cmp_pin_oe;
   logic        cmp2_pin_out, cmp2_pin_oe;
   logic [1:0]  cmp_channel_select, cmp2_channel_select;
   logic [7:0]  ctrl [2];
   logic [5:0]  view [2];
   logic [31:0] offs [5];
   logic [31:0] rst_val [5];
   int          miscompares, n_checks, seed;

   assign view[0] = {cmp_enable, cmp_ref_select, cmp_channel_select,
                     cmp_pin_oe, cmp_pin_out};
   assign view[1] = {cmp2_enable, cmp2_ref_select, cmp2_channel_select,
                     cmp2_pin_oe, cmp2_pin_out};

   dual_comparator_control_regs u_dual_comparator_control_regs
   (
      .clk, .rstn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
      .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready,
      .rdata, .rresp, .rvalid, .rready, .cmp_raw, .cmp2_raw, .cmp_enable,
      .cmp2_enable, .cmp_ref_select, .cmp2_ref_select, .cmp_channel_select,
      .cmp2_channel_select, .vref_enable, .pin_direction, .cmp_pin_out,
      .cmp_pin_oe, .cmp2_pin_out, .cmp2_pin_oe, .irq
   );

   cmp_analog_model u_cmp_analog_model
   (
      .clk, .above, .cmp_raw, .cmp2_raw, .pad,
      .enable  ({cmp2_enable, cmp_enable}),
      .pin_out ({cmp2_pin_out, cmp_pin_out}),
      .pin_oe  ({cmp2_pin_oe, cmp_pin_oe})
   );

   // ---------------------------------------------------------------
   // bench model and bus tasks
   // ---------------------------------------------------------------
   function automatic logic exp_res(int i);
      return ctrl[i][7] & (above[i] ^ ctrl[i][4]);
   endfunction : exp_res

   function automatic logic [31:0] exp_ctrl(int i);
      return {24'h0, ctrl[i][7], exp_res(i), ctrl[i][5:4], 1'b0,
              ctrl[i][2:0]};
   endfunction : exp_ctrl

   task automatic wr(input logic [31:0] a, input logic [7:0] v,
                     input logic [1:0] er = cmp_regs_pkg::RESP_OKAY);
      int t = 0;
      @(posedge clk);
      awaddr  <= a;
      wdata   <= {24'h0, v};
      wstrb   <= 4'hF;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      do
      begin
         @(posedge clk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         t++;
      end
      while (!(bvalid === 1'b1) && t < 100);
      bready <= 1'b0;
      `CHK("bresp", er, bresp)
   endtask : wr

   task automatic rd(input logic [31:0] a,
                     input logic [1:0] er = cmp_regs_pkg::RESP_OKAY);
      int t = 0;
      @(posedge clk);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      do
      begin
         @(posedge clk);
         if (arready) arvalid <= 1'b0;
         t++;
      end
      while (!(rvalid === 1'b1) && t < 100);
      d = rdata;
      rready <= 1'b0;
      `CHK("rresp", er, rresp)
   endtask : rd

   task automatic settle();
      repeat (8) @(posedge clk);
   endtask : settle

   task automatic conclude();
      $display("checks %0d miscompares %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : conclude

   // ---------------------------------------------------------------
   // clock, watchdog and tests
   // ---------------------------------------------------------------
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   initial
   begin
      // the whole run needs well under 5000 cycles
      repeat (20000) @(posedge clk);
      miscompares++;
      conclude();
   end

   initial
   begin
      {rstn, awvalid, wvalid, bready, arvalid, rready} = '0;
      {awaddr, wdata, araddr, wstrb, above} = '0;
      pin_direction = 2'h3;
      ctrl = '{8'h00, 8'h00};
      offs = '{cmp_regs_pkg::OFF_CTRL1, cmp_regs_pkg::OFF_CTRL2,
               cmp_regs_pkg::OFF_AUX, cmp_regs_pkg::OFF_STATUS,
               cmp_regs_pkg::OFF_MASK};
      rst_val = '{32'h00, 32'h00, 32'h02, 32'h00, 32'h00};
      seed = $urandom(32'h1C567EFA);
      repeat (20) @(posedge clk);
      rstn <= 1'b1;
      for (int k = 0; k < 5; k++)
      begin
         rd(offs[k]);
         `CHK("reset value", rst_val[k], d)
      end
      `CHK("off state", 8'h00, {view[0], view[1][5:4]})
      `CHK("vref off", 1'b0, vref_enable)
      wr(32'h40, 8'h5A, cmp_regs_pkg::RESP_SLVERR);
      rd(32'h40, cmp_regs_pkg::RESP_SLVERR);
      `CHK("unmapped read", 32'h0, d)
      // start-up output of a fresh comparator is junk, so flush events
      ctrl[0] = 8'h80;
      wr(offs[0], 8'h80);
      settle();
      rd(offs[0]);
      wr(offs[3], 8'h03);
      wr(offs[4], 8'h03);
      above <= 2'h1;
      settle();
      rd(offs[3]);
      `CHK("event", 32'h1, d)
      `CHK("irq", 1'b1, irq)
      wr(offs[3], 8'h01);
      settle();
      `CHK("irq cleared", 1'b0, irq)
      wr(offs[4], 8'h00);
      rd(offs[0]);
      `CHK("ctrl1", exp_ctrl(0), d)
      above <= 2'h0;
      settle();
      rd(offs[3]);
      `CHK("event after capture", 32'h1, d)
      `CHK("irq masked", 1'b0, irq)
      wr(offs[4], 8'h01);
      settle();
      `CHK("irq unmasked", 1'b1, irq)
      for (int k = 0; k < 24; k++)
      begin
         ctrl[k % 2] = 8'($urandom);
         above <= 2'($urandom);
         pin_direction <= 2'($urandom);
         wr(offs[k % 2], ctrl[k % 2]);
         settle();
         for (int i = 0; i < 2; i++)
         begin
            rd(offs[i]);
            `CHK("ctrl read", exp_ctrl(i), d)
            `CHK("core ports", {ctrl[i][7], ctrl[i][2], ctrl[i][1:0],
               ctrl[i][5] & ctrl[i][7] & ~pin_direction[i],
               exp_res(i)}, view[i])
            if (ctrl[i][5] & ctrl[i][7] & ~pin_direction[i])
               `CHK("pin level", exp_res(i), pad[i])
         end
         `CHK("vref", (ctrl[0][7] & ctrl[0][2]) |
            (ctrl[1][7] & ctrl[1][2]), vref_enable)
      end
      rstn <= 1'b0;
      repeat (3) @(posedge clk);
      rstn <= 1'b1;
      rd(offs[0]);
      `CHK("ctrl after reset", 32'h0, d)
      conclude();
   end
endmodule : dual_comparator_control_regs_bench

`default_nettype wire
